// >>> design/tbr_pkg.sv
// shared constants and carrier types for the trace buffer readout block
`default_nettype none
package tbr_pkg;
	localparam int TBR_ADDR_W = 8;
	localparam int TBR_DEPTH = 64;
	localparam int TBR_TALLY_W = 6;
	// register byte offsets
	localparam logic [7:0] TBR_OFF_TRACE = 8'h00;
	localparam logic [7:0] TBR_OFF_COUNT = 8'h04;
	localparam logic [7:0] TBR_OFF_PAGE = 8'h08;
	localparam logic [7:0] TBR_OFF_CTRL = 8'h0c;
	localparam logic [7:0] TBR_OFF_COMPC = 8'h10;
	// trace_control_one fields
	localparam int TBR_CTRL_ENABLE = 7;
	localparam int TBR_CTRL_ARM = 6;
	localparam int TBR_CTRL_BEGIN = 4;
	localparam int TBR_CTRL_BRK = 3;
	localparam int TBR_CTRL_CAP_LO = 0;
	localparam int TBR_CTRL_COMPC_BRK = 8;
	// trace_word_count and compare_c_page_extension fields
	localparam int TBR_CNT_FULL = 7;
	localparam int TBR_PAGE_SEL_LO = 6;
	localparam int TBR_EXT_W = 6;
	// reset values and bus response codes
	localparam logic [1:0] TBR_CAP_RESET = 2'h0;
	localparam logic [7:0] TBR_PAGE_RESET = 8'h00;
	localparam logic [15:0] TBR_COMPC_RESET = 16'h0000;
	localparam logic [1:0] TBR_RESP_OKAY = 2'h0;
	localparam logic [1:0] TBR_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic awvalid;
		logic [TBR_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [TBR_ADDR_W-1:0] araddr;
		logic rready;
	} tbr_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tbr_axi_rsp_type;

	typedef struct packed {
		logic [7:0] program_page_value;
		logic [15:0] cpu_addr;
		logic addr_valid;
	} tbr_core_addr_type;
endpackage
`default_nettype wire

// >>> design/tbr_trace_readout.sv
// trace buffer storage, word readout, count tracking and comparator c page compare
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
// What this block does
// - full word reads return data, advance pointer
// - byte or misaligned trace reads give zero
// - armed word reads give zero, no advance
// - trace memory has no reset clearing
// - full flag at 64 words, all valid
// - arm write clears count and full flag
// - six-bit tally counts stored words
// - wrap sets full; end mode keeps counting
// - begin mode wrap disarms, optional break
// - in end mode a full buffer overwrites oldest word circularly
// - page select picks comparator c paging
// - upper page select bit ignored
// - paged mode compares extended bits 21:16
// - comparator c usable for breakpoints
// - arm only with enable in same write
// - begin bit: trigger starts or ends storing
module tbr_trace_readout #(
	parameter int DEPTH = tbr_pkg::TBR_DEPTH
) (
	input wire logic aclk, // bus clock
	input wire logic aresetn, // synchronous reset, active low
	input wire tbr_pkg::tbr_axi_req_type axi_req, // axi4-lite master side
	output tbr_pkg::tbr_axi_rsp_type axi_rsp, // axi4-lite slave answers
	input wire logic store_valid, // capture logic offers a trace word
	input wire logic [15:0] store_word, // trace word to store
	input wire logic trigger_hit, // trigger condition met
	input wire tbr_pkg::tbr_core_addr_type core_addr, // core address and page
	output logic compare_c_match, // comparator c matched last cycle
	output logic break_request, // registered breakpoint request, held while comparator c keeps matching
	output logic trace_armed // arm state
);
	import tbr_pkg::*;

	if (DEPTH != 64) begin : g_depth_check
		$error("tbr_trace_readout supports only DEPTH 64");
	end

	logic [15:0] trace_mem [0:DEPTH-1];
	logic [TBR_TALLY_W-1:0] valid_word_tally;
	logic buffer_full_flag;
	logic [TBR_TALLY_W-1:0] read_offset;
	logic trace_unit_enable;
	logic begin_mode;
	logic trace_break_request_enable;
	logic [1:0] trace_capture_mode;
	logic compc_break_enable;
	logic triggered;
	logic [7:0] compare_c_page_extension;
	logic [15:0] compare_c_value;

	// bus write side: address and data held until both arrive
	logic aw_held;
	logic w_held;
	logic [TBR_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// answer flops kept apart so each process owns its own variables
	logic s_awready;
	logic s_wready;
	logic s_bvalid;
	logic [1:0] s_bresp;
	logic s_arready;
	logic s_rvalid;
	logic [31:0] s_rdata;
	logic [1:0] s_rresp;
	assign axi_rsp.awready = s_awready;
	assign axi_rsp.wready = s_wready;
	assign axi_rsp.bvalid = s_bvalid;
	assign axi_rsp.bresp = s_bresp;
	assign axi_rsp.arready = s_arready;
	assign axi_rsp.rvalid = s_rvalid;
	assign axi_rsp.rdata = s_rdata;
	assign axi_rsp.rresp = s_rresp;

	wire aw_fire = axi_req.awvalid & axi_rsp.awready;
	wire w_fire = axi_req.wvalid & axi_rsp.wready;
	wire write_go = aw_held & w_held & ~axi_rsp.bvalid;
	wire [7:0] wr_off = {aw_addr[TBR_ADDR_W-1:2], 2'b00};
	wire wr_ctrl = write_go & (wr_off == TBR_OFF_CTRL) & w_strb[0];
	wire wr_ctrl_hi = write_go & (wr_off == TBR_OFF_CTRL) & w_strb[1];
	wire wr_page = write_go & (wr_off == TBR_OFF_PAGE) & w_strb[0];
	wire wr_compc_lo = write_go & (wr_off == TBR_OFF_COMPC) & w_strb[0];
	wire wr_compc_hi = write_go & (wr_off == TBR_OFF_COMPC) & w_strb[1];
	wire wr_mapped = (wr_off == TBR_OFF_CTRL) | (wr_off == TBR_OFF_PAGE) |
		(wr_off == TBR_OFF_COMPC) | (wr_off == TBR_OFF_TRACE) | (wr_off == TBR_OFF_COUNT);
	// arm set only sticks when enable is set in the same write
	wire arm_write = wr_ctrl & w_data[TBR_CTRL_ARM] & w_data[TBR_CTRL_ENABLE];

	// storing: begin mode waits for the trigger, end mode stores until it
	wire storing_ok = begin_mode ? triggered : 1'b1;
	wire store_now = trace_armed & storing_ok & store_valid & ~arm_write;
	wire tally_wrap = store_now & (valid_word_tally == {TBR_TALLY_W{1'b1}});

	// read side
	wire ar_fire = axi_req.arvalid & axi_rsp.arready;
	wire [7:0] rd_off = {axi_req.araddr[TBR_ADDR_W-1:2], 2'b00};
	wire rd_aligned = (axi_req.araddr[1:0] == 2'b00);
	wire trace_read_ok = ar_fire & (rd_off == TBR_OFF_TRACE) & rd_aligned & ~trace_armed;
	// oldest word sits at the write slot once the buffer has wrapped
	wire [TBR_TALLY_W-1:0] oldest = buffer_full_flag ? valid_word_tally : '0;
	wire [TBR_TALLY_W-1:0] rd_idx = oldest + read_offset;
	wire [15:0] trace_word_out = trace_read_ok ? trace_mem[rd_idx] : 16'h0000;
	wire [31:0] ctrl_word = {23'h0, compc_break_enable, trace_unit_enable, trace_armed, 1'b0,
		begin_mode, trace_break_request_enable, 1'b0, trace_capture_mode};
	wire [31:0] count_word = {24'h0, buffer_full_flag, 1'b0, valid_word_tally};
	wire rd_mapped = (rd_off == TBR_OFF_TRACE) | (rd_off == TBR_OFF_COUNT) |
		(rd_off == TBR_OFF_PAGE) | (rd_off == TBR_OFF_CTRL) | (rd_off == TBR_OFF_COMPC);
	wire [31:0] next_rdata =
		(rd_off == TBR_OFF_TRACE) ? {16'h0000, trace_word_out} :
		(rd_off == TBR_OFF_COUNT) ? count_word :
		(rd_off == TBR_OFF_PAGE) ? {24'h0, compare_c_page_extension} :
		(rd_off == TBR_OFF_CTRL) ? ctrl_word :
		(rd_off == TBR_OFF_COMPC) ? {16'h0000, compare_c_value} : 32'h0000_0000;

	// comparator c: only the low page select bit matters
	wire paged = compare_c_page_extension[TBR_PAGE_SEL_LO];
	wire [21:0] expanded_address_bus = {core_addr.program_page_value,
		core_addr.cpu_addr[13:0]};
	wire ext_hit = expanded_address_bus[21:16] ==
		compare_c_page_extension[TBR_EXT_W-1:0];
	wire [15:0] low_addr = paged ? expanded_address_bus[15:0] : core_addr.cpu_addr;
	wire next_compare_c_match = core_addr.addr_valid & (low_addr == compare_c_value) &
		(~paged | ext_hit);
	wire next_break_request = (tally_wrap & begin_mode & trace_break_request_enable) |
		(next_compare_c_match & compc_break_enable);

	// trace words are never cleared by reset
	always_ff @(posedge aclk) begin
		if (store_now) begin
			trace_mem[valid_word_tally] <= store_word;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valid_word_tally <= '0;
			buffer_full_flag <= 1'b0;
		end else if (arm_write) begin
			valid_word_tally <= '0;
			buffer_full_flag <= 1'b0;
		end else if (store_now) begin
			valid_word_tally <= valid_word_tally + 1'b1;
			if (tally_wrap) begin
				buffer_full_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			read_offset <= '0;
		end else if (arm_write) begin
			read_offset <= '0;
		end else if (trace_read_ok) begin
			read_offset <= read_offset + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trace_unit_enable <= 1'b0;
			trace_armed <= 1'b0;
			begin_mode <= 1'b0;
			trace_break_request_enable <= 1'b0;
			trace_capture_mode <= TBR_CAP_RESET;
			triggered <= 1'b0;
		end else if (wr_ctrl) begin
			trace_unit_enable <= w_data[TBR_CTRL_ENABLE];
			trace_armed <= w_data[TBR_CTRL_ARM] & w_data[TBR_CTRL_ENABLE];
			begin_mode <= w_data[TBR_CTRL_BEGIN];
			trace_break_request_enable <= w_data[TBR_CTRL_BRK];
			trace_capture_mode <= w_data[TBR_CTRL_CAP_LO +: 2];
			triggered <= 1'b0;
		end else begin
			if (trace_armed & trigger_hit) begin
				triggered <= 1'b1;
			end
			if (tally_wrap & begin_mode) begin
				trace_armed <= 1'b0;
			end else if (trace_armed & trigger_hit & ~begin_mode) begin
				trace_armed <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			compc_break_enable <= 1'b0;
			compare_c_page_extension <= TBR_PAGE_RESET;
			compare_c_value <= TBR_COMPC_RESET;
		end else begin
			if (wr_ctrl_hi) begin
				compc_break_enable <= w_data[TBR_CTRL_COMPC_BRK];
			end
			if (wr_page) begin
				compare_c_page_extension <= w_data[7:0];
			end
			if (wr_compc_lo) begin
				compare_c_value[7:0] <= w_data[7:0];
			end
			if (wr_compc_hi) begin
				compare_c_value[15:8] <= w_data[15:8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			compare_c_match <= 1'b0;
			break_request <= 1'b0;
		end else begin
			compare_c_match <= next_compare_c_match;
			break_request <= next_break_request;
		end
	end

	// write channel: each of aw and w taken once, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= TBR_RESP_OKAY;
		end else begin
			s_awready <= ~aw_held & ~aw_fire;
			s_wready <= ~w_held & ~w_fire;
			if (aw_fire) begin
				aw_held <= 1'b1;
				aw_addr <= axi_req.awaddr;
			end
			if (w_fire) begin
				w_held <= 1'b1;
				w_data <= axi_req.wdata;
				w_strb <= axi_req.wstrb;
			end
			if (write_go) begin
				s_bvalid <= 1'b1;
				s_bresp <= wr_mapped ? TBR_RESP_OKAY : TBR_RESP_SLVERR;
			end else if (s_bvalid & axi_req.bready) begin
				s_bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_awready <= 1'b1;
				s_wready <= 1'b1;
			end
		end
	end

	// read channel: one read outstanding, data one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= TBR_RESP_OKAY;
		end else if (ar_fire) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b1;
			s_rdata <= next_rdata;
			s_rresp <= rd_mapped ? TBR_RESP_OKAY : TBR_RESP_SLVERR;
		end else if (s_rvalid & axi_req.rready) begin
			s_rvalid <= 1'b0;
			s_arready <= 1'b1;
		end else begin
			s_arready <= ~s_rvalid;
		end
	end
endmodule
`default_nettype wire

// >>> test/tbr_trace_readout_monitor.sv
// port-level assertions for the trace readout block
`default_nettype none
module tbr_trace_readout_monitor (
	input wire logic aclk, // bus clock
	input wire logic aresetn, // sync reset, low
	input wire tbr_pkg::tbr_axi_req_type axi_req, // bus requests
	input wire tbr_pkg::tbr_axi_rsp_type axi_rsp, // bus answers
	input wire logic store_valid, // word offered
	input wire logic [15:0] store_word, // offered word
	input wire logic trigger_hit, // trigger
	input wire tbr_pkg::tbr_core_addr_type core_addr, // core address
	input wire logic compare_c_match, // comparator c hit
	input wire logic break_request, // break request
	input wire logic trace_armed // arm state
);
	timeunit 1ns;
	timeprecision 1ns;
	import tbr_pkg::*;
	wire logic rd_take;
	wire logic wr_take;
	assign rd_take = axi_req.arvalid && axi_rsp.arready;
	assign wr_take = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_rd_lat; rd_take |=> axi_rsp.rvalid; endproperty
	property p_rd_busy; axi_rsp.rvalid |-> !axi_rsp.arready; endproperty
	property p_misal; rd_take && axi_req.araddr[7:2] == 6'h0 && axi_req.araddr[1:0] != 2'h0
		|=> axi_rsp.rdata == 32'h0; endproperty
	property p_armed; rd_take && axi_req.araddr == TBR_OFF_TRACE && trace_armed
		|=> axi_rsp.rdata == 32'h0; endproperty
	property p_arm_src; $rose(trace_armed) |-> $rose(axi_rsp.bvalid); endproperty
	property p_disarm; $fell(trace_armed)
		|-> $past(trigger_hit) || $past(store_valid) || $rose(axi_rsp.bvalid); endproperty
	property p_brk; break_request
		|-> compare_c_match || $past(trace_armed) || $past(trace_armed, 2); endproperty
	property p_cmp; compare_c_match |-> $past(core_addr.addr_valid); endproperty
	property p_b_lat; wr_take |=> !axi_rsp.bvalid ##[1:2] axi_rsp.bvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
	a_rd_busy: assert property (p_rd_busy) else $error("read taken while busy");
	a_misal: assert property (p_misal) else $error("misaligned read not zero");
	a_armed: assert property (p_armed) else $error("armed read not zero");
	a_arm_src: assert property (p_arm_src) else $error("arm without write");
	a_disarm: assert property (p_disarm) else $error("disarm without cause");
	a_brk: assert property (p_brk) else $error("break without cause");
	a_cmp: assert property (p_cmp) else $error("match without valid address");
	a_b_lat: assert property (p_b_lat) else $error("write answer timing");
	c_brk: cover property (break_request);
	c_match: cover property (compare_c_match);
	c_wrap: cover property ($fell(trace_armed) && !$past(trigger_hit));
endmodule
`default_nettype wire

// >>> test/tbr_core_model.sv
// capture side stand-in: emits a running sequence of trace words
`default_nettype none
module tbr_core_model (
	input wire logic aclk, // bus clock
	input wire logic run, // emit one word per cycle
	output logic store_valid, // word offered
	output logic [15:0] store_word // offered word
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] seq = 16'h0000;
	initial store_valid = 1'b0;
	initial store_word = 16'h0000;
	// idle word flips each cycle so a stale value is never mistaken for data
	always @(posedge aclk) begin
		store_valid <= run;
		if (run) begin
			store_word <= 16'h8000 + seq;
			seq <= seq + 16'h0001;
		end else begin
			store_word <= ~store_word;
		end
	end
endmodule
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the trace readout block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import tbr_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	tbr_axi_req_type req = '0;
	tbr_axi_rsp_type rsp;
	logic run = 1'b0;
	logic trig = 1'b0;
	tbr_core_addr_type core = '0;
	logic store_valid;
	logic [15:0] store_word;
	logic cmp;
	logic brk;
	logic armed;
	int num_errors = 0;
	int tests_run = 0;
	int brk_seen = 0;
	logic [31:0] d;
	logic [1:0] r;
	always #50 aclk = ~aclk;
	always @(posedge aclk) if (brk === 1'b1) brk_seen++;
	tbr_core_model u_tbr_core_model (.aclk(aclk), .run(run), .store_valid(store_valid),
		.store_word(store_word));
	tbr_trace_readout #(.DEPTH(64)) u_tbr_trace_readout (.aclk(aclk), .aresetn(aresetn),
		.axi_req(req), .axi_rsp(rsp), .store_valid(store_valid), .store_word(store_word),
		.trigger_hit(trig), .core_addr(core), .compare_c_match(cmp), .break_request(brk),
		.trace_armed(armed));
	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk_data({30'h0, got}, {30'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		req.awaddr <= a;
		req.wdata <= v;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			r = rsp.bresp;
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		chk_resp(r, TBR_RESP_OKAY);
	endtask
	task automatic rd(input logic [7:0] a);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		d = rsp.rdata;
		r = rsp.rresp;
	endtask
	// run goes through the model's register, so exactly n words are offered
	task automatic stream(input int n);
		run <= 1'b1;
		repeat (n) @(posedge aclk);
		run <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask
	task automatic pulse_trig;
		trig <= 1'b1;
		@(posedge aclk);
		trig <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		end_sim();
	end
	initial begin
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		req.rready <= 1'b1;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		wr(TBR_OFF_CTRL, 32'h40);
		chk_data({31'h0, armed}, 32'h0);
		// capture mode stays at its reset value for recording and readout alike
		wr(TBR_OFF_CTRL, 32'hc0);
		chk_data({31'h0, armed}, 32'h1);
		stream(5);
		rd(TBR_OFF_TRACE);
		chk_data(d, 32'h0);
		rd(TBR_OFF_COUNT);
		chk_data(d, 32'h5);
		pulse_trig();
		chk_data({31'h0, armed}, 32'h0);
		rd(TBR_OFF_TRACE);
		chk_data(d, 32'h8000);
		rd(8'h01);
		chk_data(d, 32'h0);
		rd(8'h02);
		chk_data(d, 32'h0);
		for (int i = 1; i < 5; i++) begin
			rd(TBR_OFF_TRACE);
			chk_data(d, 32'h8000 + i);
		end
		wr(TBR_OFF_CTRL, 32'hc0);
		rd(TBR_OFF_COUNT);
		chk_data(d, 32'h0);
		stream(70);
		pulse_trig();
		rd(TBR_OFF_COUNT);
		chk_data(d, 32'h86);
		for (int i = 0; i < 64; i++) begin
			rd(TBR_OFF_TRACE);
			chk_data(d, 32'h800b + i);
		end
		wr(TBR_OFF_CTRL, 32'hd8);
		stream(3);
		rd(TBR_OFF_COUNT);
		chk_data(d, 32'h0);
		brk_seen = 0;
		pulse_trig();
		stream(66);
		chk_data({31'h0, armed}, 32'h0);
		chk_data(brk_seen, 32'h1);
		rd(TBR_OFF_COUNT);
		chk_data(d, 32'h80);
		rd(TBR_OFF_TRACE);
		chk_data(d, 32'h804e);
		wr(TBR_OFF_COMPC, 32'h1234);
		core <= '{8'h14, 16'h9234, 1'b1};
		for (int s = 0; s < 4; s++) begin
			wr(TBR_OFF_PAGE, {24'h0, 2'(s), 6'h05});
			rd(TBR_OFF_PAGE);
			chk_data(d, {24'h0, 2'(s), 6'h05});
			repeat (2) @(posedge aclk);
			chk_data({31'h0, cmp}, 32'(s % 2));
		end
		wr(TBR_OFF_CTRL, 32'h100);
		rd(TBR_OFF_CTRL);
		chk_data(d, 32'h100);
		repeat (2) @(posedge aclk);
		chk_data({31'h0, brk}, 32'h1);
		rd(8'h14);
		chk_data(d, 32'h0);
		chk_resp(r, TBR_RESP_SLVERR);
		end_sim();
	end
endmodule
bind tbr_trace_readout tbr_trace_readout_monitor u_tbr_trace_readout_monitor (.aclk, .aresetn,
	.axi_req, .axi_rsp, .store_valid, .store_word, .trigger_hit, .core_addr, .compare_c_match,
	.break_request, .trace_armed);
`default_nettype wire
